// File: hw/regulator_map.svh
// Register indices, field positions, reset values of the regulator bank
`ifndef REGULATOR_MAP_SVH
`define REGULATOR_MAP_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_PREV_SLEEP_CTRL  16'h407c
`define IDX_MAIN_CTRL        16'h407d
`define IDX_ACTIVE_CTRL      16'h407e
`define IDX_SLEEP_CTRL       16'h407f
`define IDX_IRQ_STATUS       16'h4090
`define IDX_IRQ_MASK         16'h4091
`define ADDR_W               18

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define F_ERR_ACT_HI   15
`define F_ERR_ACT_LO   14
`define F_HWC_SRC_HI   12
`define F_HWC_SRC_LO   11
`define F_HWC_VPICK    10
`define F_HWC_MODE_HI  9
`define F_HWC_MODE_LO  8
`define F_FLOAT        7
`define F_SLOT_HI      15
`define F_SLOT_LO      13
`define F_OP_MODE      8
`define F_VOLT_HI      4
`define F_VOLT_LO      0
`define IRQ_UV         0
`define IRQ_SHUTDOWN   1
`define IRQ_BITS       2

// ------------------------------------------------------------
// Reset values and writable masks
// ------------------------------------------------------------
`define RST_PREV_SLEEP 16'h0000
`define RST_MAIN       16'h0200
`define RST_ACTIVE     16'h0000
`define RST_SLEEP      16'h0100
`define WMASK_PREV     16'h001f
`define WMASK_MAIN     16'hdf80
`define WMASK_ACTIVE   16'he11f
`define WMASK_SLEEP    16'he11f

`endif

// File: hw/regulator_pkg.sv
// Types shared by the regulator control bank
package regulator_pkg;
    typedef enum logic [1:0] {
        ERR_IGNORE,
        ERR_REG_OFF,
        ERR_SYS_RESET,
        ERR_RESERVED
    } err_action_t;

    typedef enum logic [1:0] {
        HWC_LP_A,
        HWC_OFF,
        HWC_LP_B,
        HWC_FOLLOW
    } hwc_state_t;

    typedef enum {
        ST_OFF,
        ST_ACTIVE,
        ST_SLEEP,
        ST_FAULT
    } reg_state_t;
endpackage : regulator_pkg

// File: hw/regulator_control_regs.sv
// Control register bank and state logic for one linear regulator
//
// Functional notes
// - Undervoltage action: 00 ignore, 01 regulator off, 10 system reset
// - Every undervoltage fault raises the interrupt, whatever the action
// - Hardware control source bits 12:11: off, input 1, input 2, either
// - Under hardware control bit 10 picks active or sleep voltage code
// - Hardware control state bits 9:8: low power, off, follow mode
// - Bit 7: discharge output when disabled, or leave it floating
// - Start-up slot 000 never enables; 001..101 enable in slots 1..5
// - Slot codes 110/111 hand enable to hardware enable input 1/2
// - Active mode bit 8: normal or low-power while active
// - Active voltage code bits 4:0, two-segment linear encoding
// - Preceding regulator sleep voltage code bits 4:0, reset zero
// - Sleep slot picks sleep transition or disable timeslot
// - With hardware enable, codes 001..101 pick sleep entry slot
`include "regulator_map.svh"
`timescale 1ns/1ps
`default_nettype none

module regulator_control_regs
    import regulator_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // Avalon-MM slave
    input  wire logic [`ADDR_W-1:0]   avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest,
    output logic [1:0]                avs_response,
    // Pins from outside the clock domain
    input  wire logic                 hw_ctrl_in1,
    input  wire logic                 hw_ctrl_in2,
    input  wire logic                 hw_enable_in1,
    input  wire logic                 hw_enable_in2,
    input  wire logic                 uv_fault,
    // Power sequencer, same clock
    input  wire logic [2:0]           seq_slot,
    input  wire logic                 seq_up,
    input  wire logic                 seq_down,
    input  wire logic                 seq_sleep,
    // Analogue regulator and system
    output logic                      reg_enable,
    output logic                      reg_low_power,
    output logic [4:0]                reg_volt_code,
    output logic                      reg_float,
    output logic [4:0]                prev_sleep_volt_code,
    output logic                      system_reset_req,
    output logic                      irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0]          prev_sleep_ctrl;
    logic [15:0]          regulator_main_ctrl;
    logic [15:0]          regulator_active_ctrl;
    logic [15:0]          sleep_ctrl;
    logic [`IRQ_BITS-1:0] irq_status;
    logic [`IRQ_BITS-1:0] irq_mask;
    logic                 ack;
    reg_state_t           state;
    reg_state_t           next_state;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic       uv_seen;

    // Two flops on every pin; sync_b and the uv_seen edge flop feed logic
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_a  <= 5'h00;
            sync_b  <= 5'h00;
            uv_seen <= 1'b0;
        end else begin
            sync_a  <= {uv_fault, hw_enable_in2, hw_enable_in1,
                        hw_ctrl_in2, hw_ctrl_in1};
            sync_b  <= sync_a;
            uv_seen <= sync_b[4];
        end
    end

    wire hc1      = sync_b[0];
    wire hc2      = sync_b[1];
    wire hen1     = sync_b[2];
    wire hen2     = sync_b[3];
    wire uv_level = sync_b[4];
    wire uv_rise  = uv_level & ~uv_seen;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    wire [1:0] uv_error_action   =
        regulator_main_ctrl[`F_ERR_ACT_HI:`F_ERR_ACT_LO];
    wire [1:0] hw_control_source =
        regulator_main_ctrl[`F_HWC_SRC_HI:`F_HWC_SRC_LO];
    wire       hw_control_volt_pick = regulator_main_ctrl[`F_HWC_VPICK];
    wire [1:0] hw_control_state  =
        regulator_main_ctrl[`F_HWC_MODE_HI:`F_HWC_MODE_LO];
    wire       output_float_on_disable = regulator_main_ctrl[`F_FLOAT];
    wire [2:0] active_enable_slot =
        regulator_active_ctrl[`F_SLOT_HI:`F_SLOT_LO];
    wire       active_op_mode = regulator_active_ctrl[`F_OP_MODE];
    wire [4:0] active_volt_code =
        regulator_active_ctrl[`F_VOLT_HI:`F_VOLT_LO];
    wire [2:0] sleep_exit_slot = sleep_ctrl[`F_SLOT_HI:`F_SLOT_LO];
    wire       sleep_op_mode   = sleep_ctrl[`F_OP_MODE];
    wire [4:0] sleep_volt_code = sleep_ctrl[`F_VOLT_HI:`F_VOLT_LO];

    // Slot code 1..5 means a real sequencer timeslot
    function automatic logic is_timeslot(input logic [2:0] code);
        is_timeslot = (code != 3'h0) && (code <= 3'h5);
    endfunction : is_timeslot

    // Hardware enable assignment; no start-up or power-down slot applies then
    wire hen_assigned = active_enable_slot[2] & active_enable_slot[1];
    wire hen_level    = active_enable_slot[0] ? hen2 : hen1;
    wire up_hit = seq_up & is_timeslot(active_enable_slot) &
                  (seq_slot == active_enable_slot);

    // Sleep slot decode: transition slot and whether to disable
    logic [2:0] sleep_slot_num;
    logic       sleep_disables;
    always_comb begin
        sleep_slot_num = 3'h5;
        sleep_disables = 1'b0;
        case (sleep_exit_slot)
            3'h0: sleep_slot_num = 3'h5;
            3'h6: sleep_slot_num = 3'h3;
            3'h7: sleep_slot_num = 3'h1;
            default: begin
                sleep_slot_num = 3'h6 - sleep_exit_slot;
                sleep_disables = ~hen_assigned;
            end
        endcase
    end

    wire sleep_hit = (seq_sleep | seq_down) & (seq_slot == sleep_slot_num);
    wire down_off  = seq_down & is_timeslot(active_enable_slot) &
                     (seq_slot == (3'h6 - active_enable_slot));
    wire uv_off    = uv_rise & (uv_error_action == ERR_REG_OFF);
    wire uv_sys    = uv_rise & (uv_error_action == ERR_SYS_RESET);

    // ------------------------------------------------------------
    // Regulator state
    // ------------------------------------------------------------
    // Fault shutdown holds until the next start-up slot
    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (hen_assigned) begin
                    if (hen_level)
                        next_state = ST_ACTIVE;
                end else if (up_hit) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (hen_assigned && !hen_level)
                    next_state = ST_OFF;
                else if (sleep_hit)
                    next_state = sleep_disables ? ST_OFF : ST_SLEEP;
                else if (down_off)
                    next_state = ST_OFF;
            end
            ST_SLEEP: begin
                if (up_hit || (hen_assigned && hen_level && seq_up))
                    next_state = ST_ACTIVE;
                else if (seq_down && !seq_sleep && sleep_hit)
                    next_state = ST_OFF;
            end
            ST_FAULT: begin
                if (up_hit || (hen_assigned && hen_level && seq_up))
                    next_state = ST_ACTIVE;
            end
            default: next_state = ST_OFF;
        endcase
        if (uv_off)
            next_state = ST_FAULT;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            state <= ST_OFF;
        else
            state <= next_state;
    end

    // ------------------------------------------------------------
    // Output selection
    // ------------------------------------------------------------
    // Hardware control overrides only while the regulator is enabled
    wire hwc_on = (hw_control_source[0] & hc1) |
                  (hw_control_source[1] & hc2);
    wire seq_on = (state == ST_ACTIVE) | (state == ST_SLEEP);
    wire in_sleep = (state == ST_SLEEP);

    wire [4:0] seq_volt = in_sleep ? sleep_volt_code : active_volt_code;
    wire       seq_lp   = in_sleep ? sleep_op_mode : active_op_mode;
    wire [4:0] hwc_volt = hw_control_volt_pick ? sleep_volt_code
                                               : active_volt_code;
    wire       hwc_lp   = (hw_control_state == HWC_FOLLOW) ?
                          active_op_mode : 1'b1;
    wire       hwc_kill = (hw_control_state == HWC_OFF);

    wire       use_hwc    = seq_on & hwc_on;
    wire       next_en    = seq_on & ~(use_hwc & hwc_kill);
    wire       next_lp    = use_hwc ? hwc_lp : seq_lp;
    wire [4:0] next_volt  = use_hwc ? hwc_volt : seq_volt;

    // Analogue controls come from flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_enable       <= 1'b0;
            reg_low_power    <= 1'b0;
            reg_volt_code    <= 5'h00;
            reg_float        <= 1'b0;
            system_reset_req <= 1'b0;
        end else begin
            reg_enable       <= next_en;
            reg_low_power    <= next_lp;
            reg_volt_code    <= next_volt;
            reg_float        <= output_float_on_disable;
            system_reset_req <= uv_sys;
        end
    end

    always_comb prev_sleep_volt_code = prev_sleep_ctrl[4:0];

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [`ADDR_W-1:0] a,
                                 input logic [15:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction : hit

    wire req      = avs_read | avs_write;
    wire take     = req & ~ack;
    wire wr       = take & avs_write;
    wire sel_prev = hit(avs_address, `IDX_PREV_SLEEP_CTRL);
    wire sel_main = hit(avs_address, `IDX_MAIN_CTRL);
    wire sel_act  = hit(avs_address, `IDX_ACTIVE_CTRL);
    wire sel_slp  = hit(avs_address, `IDX_SLEEP_CTRL);
    wire sel_ist  = hit(avs_address, `IDX_IRQ_STATUS);
    wire sel_imk  = hit(avs_address, `IDX_IRQ_MASK);
    wire mapped   = sel_prev | sel_main | sel_act | sel_slp |
                    sel_ist | sel_imk;
    wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [15:0] wdata   = avs_writedata[15:0];

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] nv,
                                          input logic [15:0] m);
        merge = (old & ~m) | (nv & m);
    endfunction : merge

    wire [15:0] rd_mux =
        sel_prev ? prev_sleep_ctrl :
        sel_main ? regulator_main_ctrl :
        sel_act  ? regulator_active_ctrl :
        sel_slp  ? sleep_ctrl :
        sel_ist  ? {14'h0000, irq_status} :
        sel_imk  ? {14'h0000, irq_mask} : 16'h0000;

    // One wait state per access; answer flops ride with ack
    assign avs_waitrequest = req & ~ack;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'b00;
        end else begin
            ack <= take;
            if (take) begin
                avs_readdata <= {16'h0000, rd_mux};
                avs_response <= mapped ? 2'b00 : 2'b11;
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Write masks keep reserved and omitted bits at zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_sleep_ctrl       <= `RST_PREV_SLEEP;
            regulator_main_ctrl   <= `RST_MAIN;
            regulator_active_ctrl <= `RST_ACTIVE;
            sleep_ctrl            <= `RST_SLEEP;
            irq_mask              <= {`IRQ_BITS{1'b0}};
        end else if (wr) begin
            if (sel_prev)
                prev_sleep_ctrl <= merge(prev_sleep_ctrl, wdata,
                                         be_mask & `WMASK_PREV);
            if (sel_main)
                regulator_main_ctrl <= merge(regulator_main_ctrl, wdata,
                                             be_mask & `WMASK_MAIN);
            if (sel_act)
                regulator_active_ctrl <= merge(regulator_active_ctrl, wdata,
                                               be_mask & `WMASK_ACTIVE);
            if (sel_slp)
                sleep_ctrl <= merge(sleep_ctrl, wdata,
                                    be_mask & `WMASK_SLEEP);
            if (sel_imk && avs_byteenable[0])
                irq_mask <= wdata[`IRQ_BITS-1:0];
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Set beats write-one-to-clear in the same cycle
    wire [`IRQ_BITS-1:0] irq_set = {uv_off, uv_rise};
    wire [`IRQ_BITS-1:0] irq_clr =
        (wr && sel_ist && avs_byteenable[0]) ?
        wdata[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            irq_status <= {`IRQ_BITS{1'b0}};
        else
            irq_status <= (irq_status & ~irq_clr) | irq_set;
    end

    assign irq = |(irq_status & irq_mask);

endmodule : regulator_control_regs

`default_nettype wire

// File: sim/regulator_control_regs_asserts.sv
// Port checker for the regulator control bank, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "regulator_map.svh"
module regulator_checks
    import regulator_pkg::*;
(
    input wire logic               clk,
    input wire logic               nrst,
    input wire logic [`ADDR_W-1:0] avs_address,
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic [31:0]        avs_writedata,
    input wire logic [3:0]         avs_byteenable,
    input wire logic [31:0]        avs_readdata,
    input wire logic               avs_waitrequest,
    input wire logic [1:0]         avs_response,
    input wire logic               uv_fault,
    input wire logic               reg_float,
    input wire logic [4:0]         prev_sleep_volt_code,
    input wire logic               system_reset_req,
    input wire logic               irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // --------------------------------------------------------------
    // Bus decode
    // --------------------------------------------------------------
    wire       req = avs_read | avs_write;
    wire [15:0] idx = avs_address[17:2];
    wire       mapped = idx inside {`IDX_PREV_SLEEP_CTRL, `IDX_MAIN_CTRL,
        `IDX_ACTIVE_CTRL, `IDX_SLEEP_CTRL, `IDX_IRQ_STATUS, `IDX_IRQ_MASK};
    sequence s_taken;
        req && avs_waitrequest;
    endsequence
    sequence s_prev_wr;
        s_taken ##0 (avs_write && mapped && idx == `IDX_PREV_SLEEP_CTRL
            && avs_byteenable[0]);
    endsequence
    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    a_one_wait: assert property (s_taken |=> req && !avs_waitrequest)
        else $error("bus answer late");
    a_idle_nowait: assert property (!req |-> !avs_waitrequest)
        else $error("waitrequest high with no request");
    a_unmapped_resp: assert property ((s_taken ##0 !mapped) |=>
        avs_response == 2'b11 && avs_readdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_resp: assert property ((s_taken ##0 mapped) |=>
        avs_response == 2'b00)
        else $error("mapped access refused");
    a_prev_sleep_wr: assert property (s_prev_wr |=>
        prev_sleep_volt_code == $past(avs_writedata[4:0]))
        else $error("sleep code not written");
    a_reset_pulse: assert property (system_reset_req |=> !system_reset_req)
        else $error("reset request too long");
    a_reset_cause: assert property (system_reset_req |->
        $past(uv_fault, 2) || $past(uv_fault, 3) || $past(uv_fault, 4))
        else $error("system reset request without a fault");
    a_float_cause: assert property ($changed(reg_float) |->
        $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
        else $error("float output changed without a write");
    a_irq_cause: assert property ($rose(irq) |->
        $past(avs_write) || $past(uv_fault, 2) || $past(uv_fault, 3)
        || $past(uv_fault, 4) || $past(uv_fault, 5))
        else $error("interrupt rose without a cause");
endmodule : regulator_checks
bind regulator_control_regs regulator_checks regulator_checks_i (.clk,
    .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
    .uv_fault, .reg_float, .prev_sleep_volt_code, .system_reset_req, .irq);
`default_nettype wire

// File: sim/regulator_seq_model.sv
// Behavioural power sequencer and undervoltage source
`timescale 1ns/1ps
`default_nettype none
module regulator_seq_model (
    input  wire logic  clk,
    output logic [2:0] seq_slot,
    output logic       seq_up,
    output logic       seq_down,
    output logic       seq_sleep,
    output logic       uv_fault
);
    // Idle: slot 0 lies outside the 1..5 range
    initial {seq_slot, seq_up, seq_down, seq_sleep, uv_fault} = '0;
    // Walk slots 1..5; kind 0 start-up, 1 power-down, 2 sleep
    task automatic run(input int kind);
        for (int s = 1; s <= 5; s++) begin
            seq_slot <= 3'(s);
            seq_up <= (kind == 0);
            seq_down <= (kind == 1);
            seq_sleep <= (kind == 2);
            repeat (5) @(posedge clk);
        end
        {seq_slot, seq_up, seq_down, seq_sleep} <= '0;
        repeat (5) @(posedge clk);
    endtask : run
    // Held well past the two-flop synchroniser so the edge is seen
    task automatic uv_event();
        uv_fault <= 1'b1;
        repeat (8) @(posedge clk);
        uv_fault <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : uv_event
endmodule : regulator_seq_model
`default_nettype wire

// File: sim/tb.sv
// Self-checking testbench for the regulator control bank
`timescale 1ns/1ps
`default_nettype none
`include "regulator_map.svh"
module tb
    import regulator_pkg::*;
;
    logic clk, nrst, avs_read, avs_write, hw_ctrl_in1, hw_ctrl_in2;
    logic hw_enable_in1, hw_enable_in2, avs_waitrequest, irq;
    logic [17:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdata;
    logic [3:0]  avs_byteenable;
    logic [1:0]  avs_response, rresp;
    logic [2:0]  seq_slot;
    logic seq_up, seq_down, seq_sleep, uv_fault, reg_enable, reg_low_power;
    logic reg_float, system_reset_req;
    logic [4:0]  reg_volt_code, prev_sleep_volt_code;
    logic [15:0] idx_t[6] = '{`IDX_PREV_SLEEP_CTRL, `IDX_MAIN_CTRL,
        `IDX_ACTIVE_CTRL, `IDX_SLEEP_CTRL, `IDX_IRQ_STATUS, `IDX_IRQ_MASK};
    logic [15:0] rst_t[6] = '{16'h0000, 16'h0200, 16'h0000, 16'h0100, '0, '0};
    logic [15:0] msk_t[3] = '{16'h001f, 16'hdf80, 16'he11f};
    int error_cnt = 0, checks = 0, cycles = 0, pulses = 0, n;
    regulator_control_regs regulator_control_regs_i (.clk, .nrst,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .avs_response, .hw_ctrl_in1,
        .hw_ctrl_in2, .hw_enable_in1, .hw_enable_in2, .uv_fault, .seq_slot,
        .seq_up, .seq_down, .seq_sleep, .reg_enable, .reg_low_power,
        .reg_volt_code, .reg_float, .prev_sleep_volt_code, .system_reset_req,
        .irq);
    regulator_seq_model regulator_seq_model_i (.clk, .seq_slot, .seq_up,
        .seq_down, .seq_sleep, .uv_fault);
    // ------------------------------------------------------------------
    // Clock, timeout, reset pulse count
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (system_reset_req === 1'b1) pulses <= pulses + 1;
        if (cycles == 12000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // Hold the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [15:0] idx,
                       input logic [15:0] wd);
        avs_address <= {idx, 2'b00};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {16'h0, wd};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        rresp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rd_chk(input logic [15:0] idx, input logic [15:0] exp,
                          input logic [1:0] resp);
        bus(1'b0, idx, 16'h0);
        chk(rdata, {16'h0, exp});
        chk(32'(rresp), 32'(resp));
    endtask : rd_chk
    task automatic pins(input logic c1, c2, e1, e2);
        hw_ctrl_in1 <= c1;
        hw_ctrl_in2 <= c2;
        hw_enable_in1 <= e1;
        hw_enable_in2 <= e2;
        repeat (6) @(posedge clk);
    endtask : pins
    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {hw_ctrl_in1, hw_ctrl_in2, hw_enable_in1, hw_enable_in2} = 4'h0;
        avs_byteenable = 4'h3;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        foreach (idx_t[i]) rd_chk(idx_t[i], rst_t[i], 2'b00);
        foreach (msk_t[i]) begin
            bus(1'b1, idx_t[i], 16'hffff);
            rd_chk(idx_t[i], msk_t[i], 2'b00);
        end
        chk(reg_float, 1'b1);
        avs_byteenable <= 4'h1;
        bus(1'b1, `IDX_MAIN_CTRL, 16'h0200);
        avs_byteenable <= 4'h3;
        rd_chk(`IDX_MAIN_CTRL, 16'hdf00, 2'b00);
        bus(1'b1, `IDX_PREV_SLEEP_CTRL, 16'h0015);
        chk(prev_sleep_volt_code, 5'h15);
        rd_chk(16'h4050, 16'h0, 2'b11);
        chk(reg_float, 1'b0);
        $display("register test done");
        // Start-up slots, voltage codes across the step change
        for (int c = 0; c < 6; c++) begin
            bus(1'b1, `IDX_ACTIVE_CTRL, {c[2:0], 4'h0, c[0], 3'h0, 5'(c + 12)});
            regulator_seq_model_i.run(0);
            chk(reg_enable, c != 0);
            if (c != 0) chk(reg_volt_code, c + 12);
            if (c != 0) chk(reg_low_power, c[0]);
            regulator_seq_model_i.run(1);
            chk(reg_enable, 1'b0);
        end
        // Hardware enable inputs own the enable
        for (int c = 6; c < 8; c++) begin
            bus(1'b1, `IDX_ACTIVE_CTRL, {c[2:0], 13'h0003});
            regulator_seq_model_i.run(0);
            chk(reg_enable, 1'b0);
            pins(0, 0, c == 6, c == 7);
            chk(reg_enable, 1'b1);
            pins(0, 0, 0, 0);
            chk(reg_enable, 1'b0);
            regulator_seq_model_i.run(1);
        end
        $display("slot test done");
        // Hardware control source, voltage pick and state
        bus(1'b1, `IDX_ACTIVE_CTRL, 16'h2003);
        bus(1'b1, `IDX_SLEEP_CTRL, 16'h001f);
        regulator_seq_model_i.run(0);
        for (int s = 1; s < 4; s++) for (int p = 1; p < 3; p++) begin
            bus(1'b1, `IDX_MAIN_CTRL, {3'h0, s[1:0], 1'b1, p[0], 9'h000});
            pins(p == 1, p == 2, 0, 0);
            n = (p == 1) ? s & 1 : s >> 1;
            chk(reg_volt_code, n ? 5'h1f : 5'h03);
            chk(reg_low_power, n[0]);
            pins(0, 0, 0, 0);
            chk(reg_volt_code, 5'h03);
        end
        bus(1'b1, `IDX_MAIN_CTRL, 16'h0b00);
        pins(1, 0, 0, 0);
        chk({reg_enable, reg_low_power, reg_volt_code}, 7'h43);
        bus(1'b1, `IDX_MAIN_CTRL, 16'h0900);
        repeat (6) @(posedge clk);
        chk(reg_enable, 1'b0);
        pins(0, 0, 0, 0);
        chk(reg_enable, 1'b1);
        $display("hardware control test done");
        // Undervoltage actions, interrupt in every case
        bus(1'b1, `IDX_IRQ_MASK, 16'h0003);
        for (int a = 0; a < 4; a++) begin
            regulator_seq_model_i.run(0);
            bus(1'b1, `IDX_MAIN_CTRL, {a[1:0], 14'h0200});
            n = pulses;
            regulator_seq_model_i.uv_event();
            bus(1'b0, `IDX_IRQ_STATUS, 16'h0);
            chk(rdata[0], 1'b1);
            chk(rdata[1], a == 1);
            chk(irq, 1'b1);
            if (a != 2) chk(reg_enable, a != 1);
            chk(pulses - n, a == 2);
            bus(1'b1, `IDX_IRQ_STATUS, 16'h0003);
            chk(irq, 1'b0);
        end
        bus(1'b1, `IDX_MAIN_CTRL, 16'h0200);
        bus(1'b1, `IDX_IRQ_MASK, 16'h0000);
        regulator_seq_model_i.uv_event();
        chk(irq, 1'b0);
        rd_chk(`IDX_IRQ_STATUS, 16'h0001, 2'b00);
        bus(1'b1, `IDX_IRQ_STATUS, 16'h0001);
        rd_chk(`IDX_IRQ_STATUS, 16'h0000, 2'b00);
        $display("undervoltage test done");
        // Sleep slot: transition in slot 5, then disable in slot 5
        regulator_seq_model_i.run(0);
        bus(1'b1, `IDX_SLEEP_CTRL, 16'h011f);
        regulator_seq_model_i.run(2);
        chk({reg_enable, reg_low_power, reg_volt_code}, 7'h7f);
        bus(1'b1, `IDX_SLEEP_CTRL, 16'h2000);
        regulator_seq_model_i.run(0);
        regulator_seq_model_i.run(2);
        chk(reg_enable, 1'b0);
        bus(1'b1, `IDX_ACTIVE_CTRL, 16'hc000);
        bus(1'b1, `IDX_SLEEP_CTRL, 16'h6115);
        pins(0, 0, 1, 0);
        regulator_seq_model_i.run(2);
        chk({reg_enable, reg_low_power, reg_volt_code}, 7'h75);
        $display("sleep test done");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
